// >>> logic/lbtc_defines.svh
/*
 register offsets, field positions, reset values and timing counts for the loopback and
 bit error rate test control block; assumes a 40 MHz core clock and a 32-bit APB slave.
*/
`ifndef LBTC_DEFINES_SVH
`define LBTC_DEFINES_SVH

`define LBTC_CLK_HZ 40000000
`define LBTC_INJECT_PERIOD_MS 1000
`define LBTC_INJECT_CYCLES ((`LBTC_CLK_HZ / 1000) * `LBTC_INJECT_PERIOD_MS)
`define LBTC_BIT_DIV 40

`define LBTC_ADDR_CTRL 12'h000
`define LBTC_ADDR_STATUS 12'h004
`define LBTC_ADDR_ERRCNT 12'h008
`define LBTC_ADDR_NUMCMD 12'h00c
`define LBTC_ADDR_NUMLO 12'h010
`define LBTC_ADDR_NUMHI 12'h014
`define LBTC_ADDR_DIAL 12'h018

`define LBTC_CTRL_LOCAL_BIT 0
`define LBTC_CTRL_REMOTE_BIT 1
`define LBTC_CTRL_PATTERN_BIT 2
`define LBTC_CTRL_TERMEN_BIT 3
`define LBTC_CTRL_RESET 32'h00000000

`define LBTC_NUM_DIGITS 12
`define LBTC_DIGIT_W 4

`endif

// >>> logic/lbtc_pkg.sv
/*
 types for the loopback and bit error rate test control block;
 assumes lbtc_defines.svh is available for the constants.
*/
package lbtc_pkg;
   typedef enum logic [2:0] {
      LBTC_LOOP_NONE = 3'b001,
      LBTC_LOOP_LOCAL = 3'b010,
      LBTC_LOOP_REMOTE = 3'b100
   } lbtc_loop_e;

   typedef struct packed {
      logic localLoop;
      logic remoteLoop;
      logic pattern;
      logic patternInject;
   } lbtc_panel_s;

   typedef struct packed {
      logic lineSide;
      logic dataSide;
   } lbtc_central_s;

   typedef logic [47:0] lbtc_number_t;
endpackage : lbtc_pkg

// >>> logic/lbtc_test_control.sv
/*
 loopback, pattern test and stored-number control of a digital line unit, with an APB
 register slave; assumes panel, terminal and line-sense inputs are asynchronous levels
 and that the line codec and the dialer sit outside and act on the strobes here.
*/
// How it works
// - error count restarts whenever software reads it: at zero, or at one if a bit error comes in the read cycle
// - local loop feeds transmit into receive and lights test indicator
// - local loop from panel, terminal lead or control register
// - terminal local lead counts only when terminal loop enable is set
// - remote loop from panel, terminal lead or control register
// - terminal remote lead counts only when terminal loop enable is set
// - remote loop asks far unit to echo data back over the line
// - sealing current reversal loops line receive to transmit, lights indicator
// - central office data-side signal loops data back, lights indicator
// - pattern switch sends continuous 511 pattern toward the far unit
// - detector compares against 511 sequence, pulses error per bad bit
// - inject mode flips one bit about once per second
// - pattern test runs alone or together with either loopback
// - control register can start plain 511 pattern transmission
// - inject mode only from panel, never from control port
// - stored number dialed on rising edge of terminal ready
// - empty store erases number and disables ready-triggered dialing
// - reading stored number leaves it unchanged
// - dial-new-number dials entered number, stored one unchanged
// - line violations also pulse error indicator
// - test indicator lit whenever any test mode is active
`include "lbtc_defines.svh"

module lbtc_test_control #(
   parameter int INJECT_CYCLES = `LBTC_INJECT_CYCLES,
   parameter int BIT_DIV = `LBTC_BIT_DIV
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire lbtc_pkg::lbtc_panel_s panelIn,
   input wire logic terminal_local_loop_lead,
   input wire logic terminal_remote_loop_lead,
   input wire logic terminalReady,
   input wire lbtc_pkg::lbtc_central_s centralIn,
   input wire logic lineViolation,
   input wire logic rxData,
   output logic txPatternBit,
   output logic patternActive,
   output logic local_analog_loopback,
   output logic remote_digital_loopback,
   output logic lineSideLoop,
   output logic dataSideLoop,
   output logic test_mode_indicator,
   output logic error_indicator,
   output logic dialStrobe,
   output lbtc_pkg::lbtc_number_t dialNumber
);
   initial begin
      if (BIT_DIV < 2 || INJECT_CYCLES < 2) begin
         $error("lbtc_test_control: BIT_DIV and INJECT_CYCLES must be at least 2");
      end
   end

   // three-stage synchroniser for asynchronous levels
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] asyncIn;
   logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, nxt_s1, nxt_s2, nxt_s3;
   logic [NSYNC-1:0] clean_ff, nxt_clean;
   assign asyncIn = {panelIn, terminal_local_loop_lead, terminal_remote_loop_lead,
                     terminalReady, centralIn, rxData};
   always_comb begin
      nxt_s1 = asyncIn;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
      nxt_clean = clean_ff;
      for (int i = 0; i < NSYNC; i++) begin
         if (s2_ff[i] == s3_ff[i]) begin
            nxt_clean[i] = s3_ff[i];
         end
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         clean_ff <= '0;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         s3_ff <= nxt_s3;
         clean_ff <= nxt_clean;
      end
   end
   logic pLocal, pRemote, pPattern, pInject, tLocal, tRemote, tReady, coLine, coData, rxBit;
   assign {pLocal, pRemote, pPattern, pInject, tLocal, tRemote, tReady, coLine, coData, rxBit}
      = {clean_ff[9:6], clean_ff[5], clean_ff[4], clean_ff[3], clean_ff[2], clean_ff[1],
         clean_ff[0]};

   // register file and APB
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [15:0] errCnt_ff, nxt_errCnt;
   lbtc_pkg::lbtc_number_t stored_ff, nxt_stored, entry_ff, nxt_entry;
   logic storedValid_ff, nxt_storedValid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic ready_ff, nxt_ready, err_ff, nxt_err;
   logic dial_ff, nxt_dial;
   lbtc_pkg::lbtc_number_t dialNum_ff, nxt_dialNum;
   logic readyPrev_ff, nxt_readyPrev;
   logic access, wrAcc, rdAcc, bitErr;
   assign access = psel && penable && !ready_ff;
   assign wrAcc = access && pwrite;
   assign rdAcc = access && !pwrite;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_stored = stored_ff;
      nxt_storedValid = storedValid_ff;
      nxt_entry = entry_ff;
      nxt_rdata = rdata_ff;
      nxt_ready = access;
      nxt_err = 1'b0;
      nxt_dial = 1'b0;
      nxt_dialNum = dialNum_ff;
      nxt_readyPrev = tReady;
      nxt_errCnt = errCnt_ff;
      if (rdAcc && paddr == `LBTC_ADDR_ERRCNT) begin
         nxt_errCnt = '0;
      end
      if (bitErr && nxt_errCnt != 16'hffff) begin
         nxt_errCnt = nxt_errCnt + 16'h0001;
      end
      if (tReady && !readyPrev_ff && storedValid_ff) begin
         nxt_dial = 1'b1;
         nxt_dialNum = stored_ff;
      end
      if (wrAcc) begin
         case (paddr)
            `LBTC_ADDR_CTRL: nxt_ctrl = {28'h0000000, pwdata[3:0]};
            `LBTC_ADDR_NUMLO: nxt_entry = {entry_ff[47:32], pwdata};
            `LBTC_ADDR_NUMHI: nxt_entry = {pwdata[15:0], entry_ff[31:0]};
            `LBTC_ADDR_NUMCMD: begin
               if (pwdata[0]) begin
                  nxt_stored = entry_ff;
                  nxt_storedValid = entry_ff != '0;
               end
               if (pwdata[1]) begin
                  nxt_dial = 1'b1;
                  nxt_dialNum = entry_ff;
               end
            end
            `LBTC_ADDR_STATUS, `LBTC_ADDR_ERRCNT, `LBTC_ADDR_DIAL: nxt_err = 1'b0;
            default: nxt_err = 1'b1;
         endcase
      end
      if (rdAcc) begin
         case (paddr)
            `LBTC_ADDR_CTRL: nxt_rdata = ctrl_ff;
            `LBTC_ADDR_STATUS: nxt_rdata = {24'h000000, storedValid_ff, patternActive,
               pInject, dataSideLoop, lineSideLoop, remote_digital_loopback,
               local_analog_loopback, test_mode_indicator};
            `LBTC_ADDR_ERRCNT: nxt_rdata = {16'h0000, errCnt_ff};
            `LBTC_ADDR_NUMCMD: nxt_rdata = '0;
            `LBTC_ADDR_NUMLO: nxt_rdata = stored_ff[31:0];
            `LBTC_ADDR_NUMHI: nxt_rdata = {16'h0000, stored_ff[47:32]};
            `LBTC_ADDR_DIAL: nxt_rdata = {16'h0000, dialNum_ff[47:32]};
            default: begin
               nxt_rdata = '0;
               nxt_err = 1'b1;
            end
         endcase
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= `LBTC_CTRL_RESET;
         stored_ff <= '0;
         storedValid_ff <= 1'b0;
         entry_ff <= '0;
         rdata_ff <= '0;
         ready_ff <= 1'b0;
         err_ff <= 1'b0;
         dial_ff <= 1'b0;
         dialNum_ff <= '0;
         readyPrev_ff <= 1'b0;
         errCnt_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         stored_ff <= nxt_stored;
         storedValid_ff <= nxt_storedValid;
         entry_ff <= nxt_entry;
         rdata_ff <= nxt_rdata;
         ready_ff <= nxt_ready;
         err_ff <= nxt_err;
         dial_ff <= nxt_dial;
         dialNum_ff <= nxt_dialNum;
         readyPrev_ff <= nxt_readyPrev;
         errCnt_ff <= nxt_errCnt;
      end
   end
   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = err_ff;
   assign dialStrobe = dial_ff;
   assign dialNumber = dialNum_ff;

   // loopback selection
   logic termEn, reqLocal, reqRemote;
   lbtc_pkg::lbtc_loop_e loop_ff, nxt_loop;
   assign termEn = ctrl_ff[`LBTC_CTRL_TERMEN_BIT];
   assign reqLocal = pLocal || (termEn && tLocal) || ctrl_ff[`LBTC_CTRL_LOCAL_BIT];
   assign reqRemote = pRemote || (termEn && tRemote)
      || ctrl_ff[`LBTC_CTRL_REMOTE_BIT];
   always_comb begin
      nxt_loop = loop_ff;
      case (loop_ff)
         lbtc_pkg::LBTC_LOOP_NONE: begin
            if (reqLocal) begin
               nxt_loop = lbtc_pkg::LBTC_LOOP_LOCAL;
            end else if (reqRemote) begin
               nxt_loop = lbtc_pkg::LBTC_LOOP_REMOTE;
            end
         end
         lbtc_pkg::LBTC_LOOP_LOCAL: begin
            if (!reqLocal) begin
               nxt_loop = lbtc_pkg::LBTC_LOOP_NONE;
            end
         end
         lbtc_pkg::LBTC_LOOP_REMOTE: begin
            if (!reqRemote) begin
               nxt_loop = lbtc_pkg::LBTC_LOOP_NONE;
            end
         end
         default: nxt_loop = lbtc_pkg::LBTC_LOOP_NONE;
      endcase
   end

   // pattern generator and detector
   logic [8:0] gen_ff, nxt_gen, det_ff, nxt_det;
   logic [$clog2(BIT_DIV)-1:0] div_ff, nxt_div;
   logic [$clog2(INJECT_CYCLES)-1:0] inj_ff, nxt_inj;
   logic injPend_ff, nxt_injPend;
   logic txBit_ff, nxt_txBit, errInd_ff, nxt_errInd;
   logic patOn, bitTick, expBit;
   logic patAct_ff, lal_ff, rdl_ff, lsl_ff, dsl_ff, tm_ff;
   assign patOn = pPattern || pInject || ctrl_ff[`LBTC_CTRL_PATTERN_BIT];
   assign bitTick = div_ff == '0;
   assign expBit = det_ff[8] ^ det_ff[4];
   assign bitErr = patAct_ff && bitTick && (rxBit != expBit);
   always_comb begin
      nxt_div = bitTick ? ($clog2(BIT_DIV))'(BIT_DIV - 1) : div_ff - 1'b1;
      nxt_gen = gen_ff;
      nxt_det = det_ff;
      nxt_txBit = txBit_ff;
      nxt_inj = inj_ff;
      nxt_injPend = injPend_ff;
      if (inj_ff == '0) begin
         nxt_inj = ($clog2(INJECT_CYCLES))'(INJECT_CYCLES - 1);
         nxt_injPend = pInject;
      end else begin
         nxt_inj = inj_ff - 1'b1;
      end
      if (bitTick && patOn) begin
         nxt_gen = {gen_ff[7:0], gen_ff[8] ^ gen_ff[4]};
         nxt_txBit = (gen_ff[8] ^ gen_ff[4]) ^ injPend_ff;
         if (injPend_ff) begin
            nxt_injPend = 1'b0;
         end
         nxt_det = {det_ff[7:0], rxBit};
      end
      if (gen_ff == '0) begin
         nxt_gen = 9'h1ff;
      end
      nxt_errInd = bitErr || lineViolation;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         loop_ff <= lbtc_pkg::LBTC_LOOP_NONE;
         gen_ff <= 9'h1ff;
         det_ff <= '0;
         div_ff <= '0;
         inj_ff <= '0;
         injPend_ff <= 1'b0;
         txBit_ff <= 1'b0;
         errInd_ff <= 1'b0;
         patAct_ff <= 1'b0;
         lal_ff <= 1'b0;
         rdl_ff <= 1'b0;
         lsl_ff <= 1'b0;
         dsl_ff <= 1'b0;
         tm_ff <= 1'b0;
      end else begin
         loop_ff <= nxt_loop;
         gen_ff <= nxt_gen;
         det_ff <= nxt_det;
         div_ff <= nxt_div;
         inj_ff <= nxt_inj;
         injPend_ff <= nxt_injPend;
         txBit_ff <= nxt_txBit;
         errInd_ff <= nxt_errInd;
         patAct_ff <= patOn;
         lal_ff <= nxt_loop == lbtc_pkg::LBTC_LOOP_LOCAL;
         rdl_ff <= nxt_loop == lbtc_pkg::LBTC_LOOP_REMOTE;
         lsl_ff <= coLine;
         dsl_ff <= coData;
         tm_ff <= (nxt_loop != lbtc_pkg::LBTC_LOOP_NONE) || coLine || coData
            || patOn;
      end
   end
   assign txPatternBit = txBit_ff;
   assign patternActive = patAct_ff;
   assign local_analog_loopback = lal_ff;
   assign remote_digital_loopback = rdl_ff;
   assign lineSideLoop = lsl_ff;
   assign dataSideLoop = dsl_ff;
   assign test_mode_indicator = tm_ff;
   assign error_indicator = errInd_ff;
endmodule : lbtc_test_control

// >>> test/lbtc_properties.sv
/*
 concurrent checks on the loop, indicator, error and dial ports of lbtc_test_control.
 assumes the top module's ports only; bound to every instance at the foot.
*/
module lbtc_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire lbtc_pkg::lbtc_panel_s panelIn,
   input wire lbtc_pkg::lbtc_central_s centralIn,
   input wire logic lineViolation,
   input wire logic patternActive,
   input wire logic local_analog_loopback,
   input wire logic remote_digital_loopback,
   input wire logic lineSideLoop,
   input wire logic dataSideLoop,
   input wire logic test_mode_indicator,
   input wire logic error_indicator,
   input wire logic dialStrobe
);
   logic anyTest;
   assign anyTest = local_analog_loopback | remote_digital_loopback | lineSideLoop
      | dataSideLoop | patternActive;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   loops_exclusive_a: assert property (!(local_analog_loopback && remote_digital_loopback))
      else $error("both loops active");
   local_lights_a: assert property (local_analog_loopback |-> test_mode_indicator)
      else $error("local loop without test indicator");
   line_lights_a: assert property (lineSideLoop |-> test_mode_indicator)
      else $error("line-side loop without test indicator");
   data_lights_a: assert property (dataSideLoop |-> test_mode_indicator)
      else $error("data-side loop without test indicator");
   indicator_cause_a: assert property (test_mode_indicator |-> anyTest || $past(anyTest))
      else $error("test indicator with no test active");
   violation_flags_a: assert property (lineViolation |-> ##[1:6] error_indicator)
      else $error("violation not flagged");
   dial_pulse_a: assert property (dialStrobe |=> !dialStrobe)
      else $error("dial strobe longer than one cycle");
   pattern_start_a: assert property (panelIn.pattern [*7] |-> patternActive)
      else $error("pattern switch ignored");
   line_request_a: assert property (centralIn.lineSide [*7] |-> lineSideLoop)
      else $error("sealing reversal ignored");
   data_request_a: assert property (centralIn.dataSide [*7] |-> dataSideLoop)
      else $error("data-side signal ignored");
   cover property (local_analog_loopback);
   cover property (dialStrobe);
   cover property (error_indicator && patternActive);
endmodule : lbtc_properties

bind lbtc_test_control lbtc_properties chk_i (.core_clk(core_clk), .rst(rst),
   .panelIn(panelIn), .centralIn(centralIn), .lineViolation(lineViolation),
   .patternActive(patternActive), .local_analog_loopback(local_analog_loopback),
   .remote_digital_loopback(remote_digital_loopback), .lineSideLoop(lineSideLoop),
   .dataSideLoop(dataSideLoop), .test_mode_indicator(test_mode_indicator),
   .error_indicator(error_indicator), .dialStrobe(dialStrobe));

// >>> test/lbtc_far_side.sv
/*
 far unit model: echoes the pattern back over the line, one bit flipped on command.
 assumes one clock with the block; line toggles when no pattern is sent.
*/
module lbtc_far_side (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic txPatternBit,
   input wire logic patternActive,
   input wire logic flipBit,
   output logic rxData
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxData <= 1'b0;
      end else if (patternActive) begin
         rxData <= txPatternBit ^ flipBit;
      end else begin
         rxData <= ~rxData;
      end
   end
endmodule : lbtc_far_side

// >>> test/tb_loopback_bert_test_control.sv
/*
 self-checking bench: apb access, loop requests, pattern test and dialing.
 assumes the far-side model and the bound checker are compiled alongside.
*/
module tb_loopback_bert_test_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   lbtc_pkg::lbtc_panel_s panelIn = '0;
   lbtc_pkg::lbtc_central_s centralIn = '0;
   logic termLocal = 1'b0, termRemote = 1'b0, terminalReady = 1'b0, lineViolation = 1'b0;
   logic flipBit = 1'b0, errSeen, rxData, pready, pslverr, txPatternBit, patternActive;
   logic locLoop, remLoop, lineSideLoop, dataSideLoop, testInd, errInd, dialStrobe;
   lbtc_pkg::lbtc_number_t dialNumber, num, num2;
   int mismatches = 0, checked = 0, cycles = 0, errs = 0, dials = 0, e0, d0;
   int seed = 32'hea5db6ed;

   lbtc_test_control #(.INJECT_CYCLES(200), .BIT_DIV(4)) dut (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .panelIn(panelIn),
      .terminal_local_loop_lead(termLocal), .terminal_remote_loop_lead(termRemote),
      .terminalReady(terminalReady), .centralIn(centralIn), .lineViolation(lineViolation),
      .rxData(rxData), .txPatternBit(txPatternBit), .patternActive(patternActive),
      .local_analog_loopback(locLoop), .remote_digital_loopback(remLoop),
      .lineSideLoop(lineSideLoop), .dataSideLoop(dataSideLoop), .test_mode_indicator(testInd),
      .error_indicator(errInd), .dialStrobe(dialStrobe), .dialNumber(dialNumber));
   lbtc_far_side far (.core_clk(core_clk), .rst(rst), .txPatternBit(txPatternBit),
      .patternActive(patternActive), .flipBit(flipBit), .rxData(rxData));

   // switched-call options are the operator's, outside this block
   always #12.5 core_clk = ~core_clk;

   task automatic results();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic entry(input lbtc_pkg::lbtc_number_t v, input logic [31:0] cmd);
      apb(1'b1, 12'h010, v[31:0]);
      apb(1'b1, 12'h014, {16'h0, v[47:32]});
      apb(1'b1, 12'h00c, cmd);
   endtask : entry

   // local wins a tie, indicator follows any active test
   function automatic logic [3:0] loopExp(input logic [3:0] c);
      logic l, r;
      l = c[0];
      r = c[1] & ~c[0];
      return {l, r, c[2], l | r | c[2]};
   endfunction : loopExp

   function automatic lbtc_pkg::lbtc_number_t rndNum();
      lbtc_pkg::lbtc_number_t v;
      v = '0;
      for (int i = 0; i < 12; i++) v[i*4 +: 4] = 4'($unsigned($random(seed)) % 10);
      return v;
   endfunction : rndNum

   always @(posedge core_clk) begin
      cycles++;
      if (dialStrobe === 1'b1) dials++;
      if (errInd === 1'b1) errs++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      tick(2);
      chk({locLoop, remLoop, lineSideLoop, dataSideLoop, testInd, patternActive}, 0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      for (int c = 1; c < 8; c++) begin
         apb(1'b1, 12'h000, 32'h0);
         tick(8);
         apb(1'b1, 12'h000, 32'(c));
         tick(8);
         chk({locLoop, remLoop, patternActive, testInd}, loopExp(4'(c)));
      end
      apb(1'b1, 12'h000, 32'h0);
      panelIn.localLoop <= 1'b1;
      tick(8);
      chk({locLoop, testInd}, 2'b11);
      panelIn.localLoop <= 1'b0;
      panelIn.remoteLoop <= 1'b1;
      tick(8);
      chk({locLoop, remLoop}, 2'b01);
      panelIn.remoteLoop <= 1'b0;
      termLocal <= 1'b1;
      termRemote <= 1'b1;
      tick(8);
      chk({locLoop, remLoop}, 2'b00);
      apb(1'b1, 12'h000, 32'h8);
      tick(8);
      chk({locLoop, remLoop}, 2'b10);
      termLocal <= 1'b0;
      tick(8);
      chk({locLoop, remLoop}, 2'b01);
      termRemote <= 1'b0;
      for (int i = 1; i < 4; i++) begin
         centralIn <= 2'(i);
         tick(8);
         chk({lineSideLoop, dataSideLoop, testInd}, {2'(i), 1'b1});
      end
      centralIn <= '0;
      tick(8);
      e0 = errs;
      lineViolation <= 1'b1;
      tick(1);
      lineViolation <= 1'b0;
      tick(8);
      chk(errs - e0, 1);
      apb(1'b0, 12'h020, 32'h0);
      chk({errSeen, rd}, {1'b1, 32'h0});
      panelIn.pattern <= 1'b1;
      tick(400);
      apb(1'b0, 12'h008, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      e0 = errs;
      flipBit <= 1'b1;
      tick(4);
      flipBit <= 1'b0;
      tick(60);
      chk(errs > e0, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd != 0, 1'b1);
      panelIn.pattern <= 1'b0;
      panelIn.patternInject <= 1'b1;
      tick(100);
      e0 = errs;
      tick(500);
      chk(errs > e0 + 1, 1'b1);
      panelIn.patternInject <= 1'b0;
      num = rndNum();
      entry(num, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, num[31:0]);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, {16'h0, num[47:32]});
      d0 = dials;
      terminalReady <= 1'b1;
      tick(10);
      chk(dials - d0, 1);
      chk(dialNumber, num);
      num2 = rndNum();
      d0 = dials;
      entry(num2, 32'h2);
      tick(4);
      chk(dials - d0, 1);
      chk(dialNumber, num2);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, num[31:0]);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, {16'h0, num2[47:32]});
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h80);
      terminalReady <= 1'b0;
      entry('0, 32'h1);
      tick(8);
      d0 = dials;
      terminalReady <= 1'b1;
      tick(10);
      chk(dials - d0, 0);
      results();
   end
endmodule : tb_loopback_bert_test_control
